// ### otg_ctrl_pkg.sv
package otg_ctrl_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    // ------------------------------------------------------------------
    // Register indices and byte addresses (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_IDX    = 12'h062;
    localparam logic [ADDR_W-1:0] STATUS_IDX  = 12'h067;
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = ADDR_W'(CTRL_IDX * 4);
    localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'(STATUS_IDX * 4);

    // ------------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------------
    localparam int BIT_DRIVE     = 0;
    localparam int BIT_CHARGE    = 1;
    localparam int BIT_DISCHARGE = 2;
    localparam int BIT_SRC_EXT   = 3;
    localparam int BIT_LOCAL_CONNECT  = 4;
    localparam int BIT_AUTO_PU   = 5;
    localparam int BIT_DP_PD     = 6;
    localparam int BIT_DM_PD     = 7;

    localparam logic [REG_W-1:0] CTRL_RESET = 16'h01c0;
    localparam logic [REG_W-1:0] CTRL_MASK  = 16'h0fff;

    // ------------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------------
    localparam int ST_DP_PULLUP   = 0;
    localparam int ST_AUTO_HELD   = 1;
    localparam int ST_REMOTE_DISC = 2;
    localparam int ST_VBUS_DRIVEN = 3;

    // ------------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Write channel state, Gray along idle -> one half -> response
    typedef enum logic [1:0] {
        WR_IDLE     = 2'h0,
        WR_GOT_ADDR = 2'h1,
        WR_RESP     = 2'h3,
        WR_GOT_DATA = 2'h2
    } wr_state_e;

endpackage

// ### otg_port_line_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Control bit 6 attaches the DP pull-down when set and removes it when clear.
// - With control bit 5 set, a remote disconnect turns the DP pull-up on by itself.
// - With control bit 5 clear, the DP pull-up follows only the local connect bit.
// - Control bit 4 attaches the DP pull-up when set and detaches it when clear, unless the bit 5 disconnect latch holds it on.
// - Control bit 3 picks the VBUS source: clear is the charge pump, set is external 5 V.
// - With the external source picked, the low-active port-1 power switch pin is the inverse of the drive bit.
// - Control bit 2 connects the VBUS discharge pull-down while set.
// - Control bit 1 charges VBUS through a resistor while set.
// - Control bit 0 lets the chosen source drive VBUS while set.
// - The status register is read only; writes to it change nothing.

module otg_port_line_ctrl (
    // Clock, reset, enable
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    input  wire logic                              ce,
    // AXI4-Lite write address
    input  wire logic [otg_ctrl_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]                        s_axi_awprot,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [otg_ctrl_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [otg_ctrl_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]                        s_axi_arprot,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    // AXI4-Lite read data
    output logic [otg_ctrl_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    // Line side event from the transceiver
    input  wire logic                              remote_disconnect,
    // Analog control outputs
    output logic                                   dp_pulldown_attach,
    output logic                                   dm_pulldown_attach,
    output logic                                   dp_pullup_attach,
    output logic                                   vbus_source_select,
    output logic                                   charge_pump_enable,
    output logic                                   port1_power_switch_n,
    output logic                                   vbus_discharge_enable,
    output logic                                   vbus_charge_enable,
    output logic                                   vbus_drive_enable
);
    import otg_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        // Write channel
        wr_state_e         wr_state;
        logic [ADDR_W-1:0] waddr;
        logic [REG_W-1:0]  wdata;
        logic [1:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;

        // Read channel
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;

        // Control word and the disconnect latch
        logic [REG_W-1:0]  ctrl;
        logic              auto_held;

        // Line outputs, one flop each
        logic              dp_pd;
        logic              dm_pd;
        logic              dp_pu;
        logic              src_ext;
        logic              pump_en;
        logic              psw_n;
        logic              dischg;
        logic              chg;
        logic              drive;
    } state_s;

    state_s st_q;
    state_s st_d;

    // Handshakes seen this cycle, from the registered readies only
    logic              aw_hs;
    logic              w_hs;

    // Write that lands this cycle: address, data and byte lanes
    logic              do_write;
    logic [ADDR_W-1:0] wa;
    logic [REG_W-1:0]  wd;
    logic [1:0]        ws;

    // Read-back word and the merged control word
    logic [REG_W-1:0]  status_word;
    logic [REG_W-1:0]  merged;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d        = st_q;
        aw_hs       = s_axi_awvalid & st_q.awready;
        w_hs        = s_axi_wvalid & st_q.wready;
        do_write    = 1'b0;
        wa          = st_q.waddr;
        wd          = st_q.wdata;
        ws          = st_q.wstrb;
        merged      = st_q.ctrl;

        // --------------------------------------------------------------
        // Status word
        // --------------------------------------------------------------
        // Bit 0 pull-up output, bit 1 auto latch, bit 2 live disconnect
        // level, bit 3 drive bit; the rest reads zero
        status_word = '0;
        status_word[ST_DP_PULLUP]   = st_q.dp_pu;
        status_word[ST_AUTO_HELD]   = st_q.auto_held;
        status_word[ST_REMOTE_DISC] = remote_disconnect;
        status_word[ST_VBUS_DRIVEN] = st_q.drive;

        // Low enable: every field keeps its value, bus handshakes included
        if (ce) begin
            // ----------------------------------------------------------
            // Write channel
            // ----------------------------------------------------------
            // Address and data are taken in either order; a half that
            // arrives alone is parked until the other one comes
            case (st_q.wr_state)
                WR_IDLE: begin
                    // Both halves together: the write lands at once
                    if (aw_hs && w_hs) begin
                        wa       = s_axi_awaddr;
                        wd       = s_axi_wdata[REG_W-1:0];
                        ws       = s_axi_wstrb[1:0];
                        do_write = 1'b1;
                        st_d.wr_state = WR_RESP;
                    end else if (aw_hs) begin
                        st_d.waddr    = s_axi_awaddr;
                        st_d.wr_state = WR_GOT_ADDR;
                    end else if (w_hs) begin
                        st_d.wdata    = s_axi_wdata[REG_W-1:0];
                        st_d.wstrb    = s_axi_wstrb[1:0];
                        st_d.wr_state = WR_GOT_DATA;
                    end
                end
                WR_GOT_ADDR: begin
                    // Address parked, data still owed
                    if (w_hs) begin
                        wd       = s_axi_wdata[REG_W-1:0];
                        ws       = s_axi_wstrb[1:0];
                        do_write = 1'b1;
                        st_d.wr_state = WR_RESP;
                    end
                end
                WR_GOT_DATA: begin
                    // Data parked, address still owed
                    if (aw_hs) begin
                        wa       = s_axi_awaddr;
                        do_write = 1'b1;
                        st_d.wr_state = WR_RESP;
                    end
                end
                WR_RESP: begin
                    // Response stands until the master takes it
                    if (s_axi_bready) begin
                        st_d.bvalid   = 1'b0;
                        st_d.wr_state = WR_IDLE;
                    end
                end
                default: begin
                    // All four codes are used; an unknown (X) state falls back to idle
                    st_d.wr_state = WR_IDLE;
                end
            endcase

            // ----------------------------------------------------------
            // Register update
            // ----------------------------------------------------------
            // Status writes are answered OKAY and dropped, so a driver that
            // sweeps the map cannot disturb the line outputs
            if (do_write) begin
                st_d.bvalid = 1'b1;
                if (wa == CTRL_ADDR) begin
                    // Lane 0 is the low byte, lane 1 the high byte; the
                    // mask keeps the reserved top bits at zero
                    if (ws[0]) begin
                        merged[7:0] = wd[7:0];
                    end
                    if (ws[1]) begin
                        merged[15:8] = wd[15:8];
                    end
                    st_d.ctrl  = merged & CTRL_MASK;
                    st_d.bresp = RESP_OKAY;
                end else if (wa == STATUS_ADDR) begin
                    st_d.bresp = RESP_OKAY;
                end else begin
                    st_d.bresp = RESP_DECERR;
                end
            end

            // ----------------------------------------------------------
            // Readies
            // ----------------------------------------------------------
            // Registered, so a half already taken is refused until the
            // response has gone; this costs one idle cycle between writes
            st_d.awready = (st_d.wr_state == WR_IDLE) || (st_d.wr_state == WR_GOT_DATA);
            st_d.wready  = (st_d.wr_state == WR_IDLE) || (st_d.wr_state == WR_GOT_ADDR);

            // ----------------------------------------------------------
            // Read channel
            // ----------------------------------------------------------
            // One read at a time; a read taken on the edge of a write sees
            // the control word as it stood before that edge
            if (st_q.rvalid) begin
                // Answer stands until the master takes it
                if (s_axi_rready) begin
                    st_d.rvalid  = 1'b0;
                    st_d.arready = 1'b1;
                end
            end else if (s_axi_arvalid && st_q.arready) begin
                st_d.rvalid  = 1'b1;
                st_d.arready = 1'b0;
                st_d.rdata   = '0;
                st_d.rresp   = RESP_OKAY;
                if (s_axi_araddr == CTRL_ADDR) begin
                    st_d.rdata[REG_W-1:0] = st_q.ctrl;
                end else if (s_axi_araddr == STATUS_ADDR) begin
                    st_d.rdata[REG_W-1:0] = status_word;
                end else begin
                    // Unmapped: zero data and a decode error
                    st_d.rresp = RESP_DECERR;
                end
            end

            // ----------------------------------------------------------
            // Automatic pull-up on disconnect
            // ----------------------------------------------------------
            // Armed by bit 5; clearing bit 5 drops the latch on that same
            // edge, so the pull-up goes straight back to the connect bit
            if (!st_d.ctrl[BIT_AUTO_PU]) begin
                st_d.auto_held = 1'b0;
            end else if (remote_disconnect) begin
                st_d.auto_held = 1'b1;
            end

            // ----------------------------------------------------------
            // Line outputs
            // ----------------------------------------------------------
            // They follow the next control value, so they settle on the
            // same edge as the register itself. The A or B role is not
            // known here: bits meant for one role are not policed
            st_d.dp_pd   = st_d.ctrl[BIT_DP_PD];
            st_d.dm_pd   = st_d.ctrl[BIT_DM_PD];
            st_d.dp_pu   = st_d.ctrl[BIT_LOCAL_CONNECT] | st_d.auto_held;
            st_d.src_ext = st_d.ctrl[BIT_SRC_EXT];
            st_d.drive   = st_d.ctrl[BIT_DRIVE];
            // Pump runs only when driving from the internal source
            st_d.pump_en = st_d.ctrl[BIT_DRIVE] & ~st_d.ctrl[BIT_SRC_EXT];
            // Switch pin is low-active; only the external path uses it
            st_d.psw_n   = ~(st_d.ctrl[BIT_DRIVE] & st_d.ctrl[BIT_SRC_EXT]);
            st_d.dischg  = st_d.ctrl[BIT_DISCHARGE];
            st_d.chg     = st_d.ctrl[BIT_CHARGE];
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // A low enable holds off reset too, so a frozen block keeps every bit;
    // line outputs leave reset already matching the reset control word
    always_ff @(posedge aclk) begin
        if (ce) begin
            if (!aresetn) begin
                // Bus idle, every channel ready
                st_q.wr_state  <= WR_IDLE;
                st_q.waddr     <= '0;
                st_q.wdata     <= '0;
                st_q.wstrb     <= '0;
                st_q.awready   <= 1'b1;
                st_q.wready    <= 1'b1;
                st_q.bvalid    <= 1'b0;
                st_q.bresp     <= RESP_OKAY;
                st_q.arready   <= 1'b1;
                st_q.rvalid    <= 1'b0;
                st_q.rdata     <= '0;
                st_q.rresp     <= RESP_OKAY;
                // Control word and its outputs
                st_q.ctrl      <= CTRL_RESET;
                st_q.auto_held <= 1'b0;
                st_q.dp_pd     <= CTRL_RESET[BIT_DP_PD];
                st_q.dm_pd     <= CTRL_RESET[BIT_DM_PD];
                st_q.dp_pu     <= CTRL_RESET[BIT_LOCAL_CONNECT];
                st_q.src_ext   <= CTRL_RESET[BIT_SRC_EXT];
                st_q.pump_en   <= CTRL_RESET[BIT_DRIVE] & ~CTRL_RESET[BIT_SRC_EXT];
                st_q.psw_n     <= ~(CTRL_RESET[BIT_DRIVE] & CTRL_RESET[BIT_SRC_EXT]);
                st_q.dischg    <= CTRL_RESET[BIT_DISCHARGE];
                st_q.chg       <= CTRL_RESET[BIT_CHARGE];
                st_q.drive     <= CTRL_RESET[BIT_DRIVE];
            end else begin
                st_q <= st_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    // Bus side
    assign s_axi_awready         = st_q.awready;
    assign s_axi_wready          = st_q.wready;
    assign s_axi_bvalid          = st_q.bvalid;
    assign s_axi_bresp           = st_q.bresp;
    assign s_axi_arready         = st_q.arready;
    assign s_axi_rvalid          = st_q.rvalid;
    assign s_axi_rdata           = st_q.rdata;
    assign s_axi_rresp           = st_q.rresp;

    // Line side
    assign dp_pulldown_attach    = st_q.dp_pd;
    assign dm_pulldown_attach    = st_q.dm_pd;
    assign dp_pullup_attach      = st_q.dp_pu;
    assign vbus_source_select    = st_q.src_ext;
    assign charge_pump_enable    = st_q.pump_en;
    assign port1_power_switch_n  = st_q.psw_n;
    assign vbus_discharge_enable = st_q.dischg;
    assign vbus_charge_enable    = st_q.chg;
    assign vbus_drive_enable     = st_q.drive;

endmodule

// ### otg_port_line_sva.sv
`timescale 1ns/1ps
// ----
// Control output checker
// ----
module otg_port_line_sva (
    // Clock, reset, enable
    input wire logic                            aclk,
    input wire logic                            aresetn,
    input wire logic                            ce,
    // Write side of the bus
    input wire logic [otg_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic                            s_axi_awvalid,
    input wire logic                            s_axi_awready,
    input wire logic [otg_ctrl_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0]                      s_axi_wstrb,
    input wire logic                            s_axi_wvalid,
    input wire logic                            s_axi_wready,
    input wire logic [1:0]                      s_axi_bresp,
    input wire logic                            s_axi_bvalid,
    // Line side
    input wire logic                            remote_disconnect,
    input wire logic                            dp_pulldown_attach,
    input wire logic                            dp_pullup_attach,
    input wire logic                            vbus_source_select,
    input wire logic                            port1_power_switch_n,
    input wire logic                            vbus_discharge_enable,
    input wire logic                            vbus_charge_enable,
    input wire logic                            vbus_drive_enable
);
    import otg_ctrl_pkg::*;
    logic       wr_take, wr_ctrl, wr_stat, auto_q;
    logic [4:0] held;

    // Only writes offering both halves at once are tracked; the bench always does so
    assign wr_take = ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign wr_ctrl = wr_take && s_axi_wstrb[0] && (s_axi_awaddr == CTRL_ADDR);
    assign wr_stat = wr_take && (s_axi_awaddr == STATUS_ADDR);
    assign held = {dp_pulldown_attach, vbus_source_select, vbus_discharge_enable,
                   vbus_charge_enable, vbus_drive_enable};

    // Shadow of the auto pull-up bit, the block hides it behind the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) auto_q <= 1'b0;
        else if (wr_ctrl) auto_q <= s_axi_wdata[BIT_AUTO_PU];
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_dp_pulldown: assert property (
        wr_ctrl |=> dp_pulldown_attach == $past(s_axi_wdata[BIT_DP_PD])) else $error("pull-down");
    a_auto_pullup: assert property (
        ce && auto_q && remote_disconnect && !wr_ctrl |=> dp_pullup_attach) else $error("auto");
    a_pullup_local: assert property (
        ce && !auto_q && !wr_ctrl |=> $stable(dp_pullup_attach)) else $error("pull-up moved");
    a_pullup_write: assert property (
        wr_ctrl && !s_axi_wdata[BIT_AUTO_PU] |=>
        dp_pullup_attach == $past(s_axi_wdata[BIT_LOCAL_CONNECT])) else $error("pull-up");
    a_source_sel: assert property (
        wr_ctrl |=> vbus_source_select == $past(s_axi_wdata[BIT_SRC_EXT])) else $error("source");
    a_power_switch: assert property (
        port1_power_switch_n == !(vbus_drive_enable && vbus_source_select)) else $error("switch");
    a_discharge_bit: assert property (
        wr_ctrl |=> vbus_discharge_enable == $past(s_axi_wdata[BIT_DISCHARGE]))
        else $error("discharge");
    a_charge_bit: assert property (
        wr_ctrl |=> vbus_charge_enable == $past(s_axi_wdata[BIT_CHARGE])) else $error("charge");
    a_drive_bit: assert property (
        wr_ctrl |=> vbus_drive_enable == $past(s_axi_wdata[BIT_DRIVE])) else $error("drive");
    a_status_ro: assert property (
        wr_stat |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY && $stable(held))
        else $error("status write took effect");
    a_bits_hold: assert property (
        ce && !wr_ctrl |=> $stable(held)) else $error("control bit changed alone");
endmodule

bind otg_port_line_ctrl otg_port_line_sva chk (.*);

// ### otg_peer_model.sv
`timescale 1ns/1ps
// ----
// Peer across the cable
// ----
module otg_peer_model (
    // Clock
    input  wire logic aclk,
    // Bench request to pull the plug
    input  wire logic unplug,
    // Disconnect event, one cycle, synchronous to aclk
    output logic      remote_disconnect = 1'b0
);
    // Registered so the event never lands on the edge the bench moves
    always @(posedge aclk) begin
        remote_disconnect <= unplug;
    end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import otg_ctrl_pkg::*;
    // ----
    // Signals
    // ----
    logic              aclk = 1'b0, aresetn = 1'b0, unplug = 1'b0, ce = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic              s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              remote_disconnect, dp_pulldown_attach, dm_pulldown_attach;
    logic              dp_pullup_attach, vbus_source_select, charge_pump_enable;
    logic              port1_power_switch_n, vbus_discharge_enable, vbus_charge_enable;
    logic              vbus_drive_enable;
    logic [8:0]        outs;
    int                mismatches = 0, num_checks = 0;

    assign outs = {dm_pulldown_attach, dp_pulldown_attach, dp_pullup_attach, vbus_source_select,
                   vbus_discharge_enable, vbus_charge_enable, vbus_drive_enable,
                   charge_pump_enable, port1_power_switch_n};
    always #2.5 aclk = ~aclk;

    otg_port_line_ctrl DUT (.*, .ce(ce), .s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
                            .s_axi_wstrb(4'hf));
    otg_peer_model peer (.aclk(aclk), .unplug(unplug), .remote_disconnect(remote_disconnect));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Expected line outputs while no disconnect latch is held
    function automatic logic [8:0] outs_exp(input logic [7:0] d);
        return {d[7], d[6], d[4], d[3], d[2], d[1], d[0], d[0] & ~d[3], ~(d[0] & d[3])};
    endfunction
    // Bus master: bready and rready stay high, so only valids move
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata & m, e);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    task automatic pulse;
        unplug <= 1'b1;
        @(posedge aclk);
        unplug <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rd(CTRL_ADDR, 32'(CTRL_RESET), '1, RESP_OKAY);
        chk(32'(outs), 32'(outs_exp(CTRL_RESET[7:0])));
        rd(STATUS_ADDR, 32'h0, '1, RESP_OKAY);
    endtask
    task automatic t_bits;
        // Drive bit never set together with a B-device bit
        logic [7:0] pat [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h09, 8'h10, 8'h40, 8'h80, 8'h00};
        foreach (pat[i]) begin
            wr(CTRL_ADDR, 32'(pat[i]), RESP_OKAY);
            chk(32'(outs), 32'(outs_exp(pat[i])));
            rd(CTRL_ADDR, 32'(pat[i]), '1, RESP_OKAY);
        end
    endtask
    task automatic t_auto;
        pulse();
        chk(32'(dp_pullup_attach), 32'h0);
        wr(CTRL_ADDR, 32'h20, RESP_OKAY);
        chk(32'(dp_pullup_attach), 32'h0);
        pulse();
        chk(32'(dp_pullup_attach), 32'h1);
        rd(STATUS_ADDR, 32'h3, 32'hf, RESP_OKAY);
        wr(CTRL_ADDR, 32'h30, RESP_OKAY);
        wr(CTRL_ADDR, 32'h10, RESP_OKAY);
        chk(32'(dp_pullup_attach), 32'h1);
        wr(CTRL_ADDR, 32'h00, RESP_OKAY);
        chk(32'(dp_pullup_attach), 32'h0);
    endtask
    task automatic t_refuse;
        wr(CTRL_ADDR, 32'h5a, RESP_OKAY);
        wr(STATUS_ADDR, 32'hffff, RESP_OKAY);
        chk(32'(outs), 32'(outs_exp(8'h5a)));
        wr(12'h000, 32'hffff, RESP_DECERR);
        rd(12'h000, 32'h0, '1, RESP_DECERR);
        rd(CTRL_ADDR, 32'h5a, '1, RESP_OKAY);
    endtask
    // Low enable freezes the latch: a disconnect seen while frozen is lost
    task automatic t_freeze;
        wr(CTRL_ADDR, 32'h20, RESP_OKAY);
        ce <= 1'b0;
        pulse();
        chk(32'(dp_pullup_attach), 32'h0);
        ce <= 1'b1;
        pulse();
        chk(32'(dp_pullup_attach), 32'h1);
        wr(CTRL_ADDR, 32'h00, RESP_OKAY);
        chk(32'(dp_pullup_attach), 32'h0);
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_bits();
        t_auto();
        t_refuse();
        t_freeze();
        tally_and_finish();
    end
    // Watchdog, far beyond the hundred or so cycles the tests take
    initial begin
        #50000;
        mismatches++;
        tally_and_finish();
    end
endmodule
